// ===== hw/user_output_consts.vh
// Constants for the user-defined output comparators
`ifndef USER_OUTPUT_CONSTS_VH
`define USER_OUTPUT_CONSTS_VH

// ==========================================================
// Register byte offsets, one aligned word each
`define OFS_C1_VARSEL   8'h00
`define OFS_C1_METHOD   8'h04
`define OFS_C1_DEADZONE 8'h08
`define OFS_C1_VALUE_A  8'h0c
`define OFS_C1_VALUE_B  8'h10
`define OFS_C2_VARSEL   8'h14
`define OFS_C2_METHOD   8'h18
`define OFS_C2_DEADZONE 8'h1c
`define OFS_C2_VALUE_A  8'h20
`define OFS_C2_VALUE_B  8'h24
`define OFS_TERM0_FUNC  8'h28
`define OFS_TERM1_FUNC  8'h2c
`define OFS_TERM2_FUNC  8'h30
`define OFS_POLARITY    8'h34
`define OFS_STATUS      8'h38

// ==========================================================
// Setting limits
`define VARSEL_MAX      6'h31
`define METHOD_MAX      4'he
`define METHOD_TRUE_MIN 4'ha

// ==========================================================
// Comparison tests (units digit of the method)
`define TEST_EQUAL      3'h0
`define TEST_AT_LEAST   3'h1
`define TEST_AT_MOST    3'h2
`define TEST_WINDOW     3'h3
`define TEST_BITS       3'h4

// ==========================================================
// Terminal function codes and status fields
`define FUNC_USER1      6'h29
`define FUNC_USER2      6'h2a
`define STAT_CMP_LSB    0
`define STAT_TERM_LSB   4

// ==========================================================
// Reset values
`define RST_SETTING     16'h0000
`define RST_FUNC        6'h00
`define RST_POLARITY    3'h0

`endif

// ===== hw/user_output_comparator.v
// One comparator: test, dead zone and output sense
`timescale 1ns/1ps
`include "user_output_consts.vh"

module user_output_comparator #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         clock,
  input  wire         arst_n,
  // Selected reference variable
  input  wire [W-1:0] refValue,
  // Settings
  input  wire [3:0]   method,
  input  wire [W-1:0] deadZone,
  input  wire [W-1:0] valueA,
  input  wire [W-1:0] valueB,
  // Result after output sense
  output reg          result_q
);

  // ========================================================
  // Method decoding
  wire       senseTrue;
  wire [3:0] unitsRaw;
  wire [2:0] testSel;
  wire       unitsValid;

  assign senseTrue  = (method >= `METHOD_TRUE_MIN);
  assign unitsRaw   = senseTrue ? method - `METHOD_TRUE_MIN
                                : method;
  assign unitsValid = (unitsRaw <= 4'h4);
  assign testSel    = unitsRaw[2:0];

  // ========================================================
  // Band edges, one bit wider so they never wrap
  wire [W:0]  bandHigh;
  wire [W:0]  refWide;
  wire        aboveHigh;
  wire        belowLow;

  assign bandHigh  = {1'b0, valueA} + {1'b0, deadZone};
  assign refWide   = {1'b0, refValue} + {1'b0, deadZone};
  assign aboveHigh = ({1'b0, refValue} >= bandHigh);
  // ref <= A - dz rewritten as ref + dz <= A
  assign belowLow  = (refWide <= {1'b0, valueA});

  // ========================================================
  // Hysteresis state for the two banded tests
  reg  holdQ;
  reg  holdD;
  reg  condition;

  always @* begin
    holdD = holdQ;
    if (testSel == `TEST_AT_LEAST) begin
      if (aboveHigh)
        holdD = 1'b1;
      else if (belowLow)
        holdD = 1'b0;
    end else if (testSel == `TEST_AT_MOST) begin
      // Set wins when both edges meet at zero width
      if (belowLow)
        holdD = 1'b1;
      else if (aboveHigh)
        holdD = 1'b0;
    end
  end

  always @* begin
    condition = 1'b0;
    if (unitsValid) begin
      case (testSel)
        `TEST_EQUAL:    condition = (refValue == valueA);
        `TEST_AT_LEAST: condition = holdD;
        `TEST_AT_MOST:  condition = holdD;
        `TEST_WINDOW:   condition = (refValue > valueA) &&
                                    (refValue <= valueB);
        `TEST_BITS:     condition = ((refValue & valueA) ==
                                     valueB);
        default:        condition = 1'b0;
      endcase
    end
  end

  // Registered state and result
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      holdQ    <= 1'b0;
      result_q <= 1'b0;
    end else begin
      holdQ    <= holdD;
      result_q <= senseTrue ? condition : ~condition;
    end
  end

endmodule

// ===== hw/user_output_block.v
// Two user-defined output comparators driving output terminals
//
// Functional notes
// - Inverse polarity: active means disconnected
// - Each comparator selects variable zero to 49
// - Method 0-14, units digit picks test
// - Tens digit: true or false output sense
// - Dead zone only for tests 1, 2
// - Method 11: set at or above A+dz, clear at or below A-dz
// - Two compare values, each 0 to 65535
// - Second comparator identical to the first
// - Function 41 follows comparator 1, 42 comparator 2
// - Positive polarity: active means connected
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "user_output_consts.vh"

module user_output_block #(
  parameter NUM_VARS  = 50,
  parameter VAR_W     = 16,
  parameter NUM_TERMS = 3
) (
  // Clock and reset
  input  wire                     clock,
  input  wire                     arst_n,
  // Register port
  input  wire [7:0]               regAddr,
  input  wire [31:0]              regWrData,
  input  wire                     regWrite,
  input  wire                     regRead,
  output reg  [31:0]              regRdData_q,
  // Internal quantities, index 0 in the low bits
  input  wire [NUM_VARS*VAR_W-1:0] variables,
  // Activity from the other terminal functions
  input  wire [NUM_TERMS-1:0]     externalActive,
  // Terminal contacts, high when closed to common
  output reg  [NUM_TERMS-1:0]     termClosed_q
);

  // ========================================================
  // Helpers

  // Extract one variable from the flat input
  function [VAR_W-1:0] pickVar;
    input [NUM_VARS*VAR_W-1:0] all;
    input [5:0]                sel;
    integer                    k;
    begin
      pickVar = {VAR_W{1'b0}};
      for (k = 0; k < NUM_VARS; k = k + 1) begin
        if (sel == k[5:0])
          pickVar = all[k*VAR_W +: VAR_W];
      end
    end
  endfunction

  // Terminal activity from its function code
  function termActive;
    input [5:0] func;
    input       cmp1;
    input       cmp2;
    input       ext;
    begin
      if (func == `FUNC_USER1)
        termActive = cmp1;
      else if (func == `FUNC_USER2)
        termActive = cmp2;
      else
        termActive = ext;
    end
  endfunction

  // ========================================================
  // Comparator settings
  reg  [5:0]       c1VarSel_q;
  reg  [3:0]       c1Method_q;
  reg  [VAR_W-1:0] c1DeadZone_q;
  reg  [VAR_W-1:0] c1ValueA_q;
  reg  [VAR_W-1:0] c1ValueB_q;
  reg  [5:0]       c2VarSel_q;
  reg  [3:0]       c2Method_q;
  reg  [VAR_W-1:0] c2DeadZone_q;
  reg  [VAR_W-1:0] c2ValueA_q;
  reg  [VAR_W-1:0] c2ValueB_q;

  // Terminal settings
  reg  [5:0]           term0Func_q;
  reg  [5:0]           term1Func_q;
  reg  [5:0]           term2Func_q;
  reg  [NUM_TERMS-1:0] polarity_q;

  // ========================================================
  // Write qualification
  wire       varSelOk;
  wire       methodOk;
  wire [5:0] wrVarSel;
  wire [3:0] wrMethod;

  assign varSelOk = (regWrData[31:6] == 26'h0) &&
                    (regWrData[5:0] <= `VARSEL_MAX);
  assign methodOk = (regWrData[31:4] == 28'h0) &&
                    (regWrData[3:0] <= `METHOD_MAX);
  assign wrVarSel = regWrData[5:0];
  assign wrMethod = regWrData[3:0];

  // ========================================================
  // Register writes
  // Value, function and polarity fields take the low bits; select and method writes with upper bits set are dropped
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      c1VarSel_q   <= 6'h00;
      c1Method_q   <= 4'h0;
      c1DeadZone_q <= `RST_SETTING;
      c1ValueA_q   <= `RST_SETTING;
      c1ValueB_q   <= `RST_SETTING;
      c2VarSel_q   <= 6'h00;
      c2Method_q   <= 4'h0;
      c2DeadZone_q <= `RST_SETTING;
      c2ValueA_q   <= `RST_SETTING;
      c2ValueB_q   <= `RST_SETTING;
      term0Func_q  <= `RST_FUNC;
      term1Func_q  <= `RST_FUNC;
      term2Func_q  <= `RST_FUNC;
      polarity_q   <= `RST_POLARITY;
    end else if (regWrite) begin
      case (regAddr)
        `OFS_C1_VARSEL: begin
          if (varSelOk)
            c1VarSel_q <= wrVarSel;
        end
        `OFS_C1_METHOD: begin
          if (methodOk)
            c1Method_q <= wrMethod;
        end
        `OFS_C1_DEADZONE: begin
          c1DeadZone_q <= regWrData[VAR_W-1:0];
        end
        `OFS_C1_VALUE_A: begin
          c1ValueA_q <= regWrData[VAR_W-1:0];
        end
        `OFS_C1_VALUE_B: begin
          c1ValueB_q <= regWrData[VAR_W-1:0];
        end
        `OFS_C2_VARSEL: begin
          if (varSelOk)
            c2VarSel_q <= wrVarSel;
        end
        `OFS_C2_METHOD: begin
          if (methodOk)
            c2Method_q <= wrMethod;
        end
        `OFS_C2_DEADZONE: begin
          c2DeadZone_q <= regWrData[VAR_W-1:0];
        end
        `OFS_C2_VALUE_A: begin
          c2ValueA_q <= regWrData[VAR_W-1:0];
        end
        `OFS_C2_VALUE_B: begin
          c2ValueB_q <= regWrData[VAR_W-1:0];
        end
        `OFS_TERM0_FUNC: begin
          term0Func_q <= regWrData[5:0];
        end
        `OFS_TERM1_FUNC: begin
          term1Func_q <= regWrData[5:0];
        end
        `OFS_TERM2_FUNC: begin
          term2Func_q <= regWrData[5:0];
        end
        `OFS_POLARITY: begin
          polarity_q <= regWrData[NUM_TERMS-1:0];
        end
        default: begin
          c1VarSel_q <= c1VarSel_q;
        end
      endcase
    end
  end

  // ========================================================
  // Reference variable selection
  wire [VAR_W-1:0] c1Ref;
  wire [VAR_W-1:0] c2Ref;

  assign c1Ref = pickVar(variables, c1VarSel_q);
  assign c2Ref = pickVar(variables, c2VarSel_q);

  // ========================================================
  // The two comparators
  wire c1Result;
  wire c2Result;

  user_output_comparator #(
    .W (VAR_W)
  ) u_cmp1 (
    .clock    (clock),
    .arst_n   (arst_n),
    .refValue (c1Ref),
    .method   (c1Method_q),
    .deadZone (c1DeadZone_q),
    .valueA   (c1ValueA_q),
    .valueB   (c1ValueB_q),
    .result_q (c1Result)
  );

  user_output_comparator #(
    .W (VAR_W)
  ) u_cmp2 (
    .clock    (clock),
    .arst_n   (arst_n),
    .refValue (c2Ref),
    .method   (c2Method_q),
    .deadZone (c2DeadZone_q),
    .valueA   (c2ValueA_q),
    .valueB   (c2ValueB_q),
    .result_q (c2Result)
  );

  // ========================================================
  // Terminal drive
  wire [5:0]           termFunc [0:NUM_TERMS-1];
  reg  [NUM_TERMS-1:0] termActiveD;
  reg  [NUM_TERMS-1:0] termClosedD;
  integer              t;

  assign termFunc[0] = term0Func_q;
  assign termFunc[1] = term1Func_q;
  assign termFunc[2] = term2Func_q;

  // Activity, then contact state by polarity
  always @* begin
    termActiveD = {NUM_TERMS{1'b0}};
    termClosedD = {NUM_TERMS{1'b0}};
    for (t = 0; t < NUM_TERMS; t = t + 1) begin
      // codes 41 and 42 route results
      termActiveD[t] = termActive(termFunc[t], c1Result,
                                  c2Result,
                                  externalActive[t]);
      termClosedD[t] = polarity_q[t] ? ~termActiveD[t]
                                     : termActiveD[t];
    end
  end

  // Contacts change only on the clock edge or when reset clears them
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      termClosed_q <= {NUM_TERMS{1'b0}};
    else
      termClosed_q <= termClosedD;
  end

  // ========================================================
  // Read-back
  reg [31:0] rdMux;

  // Unmapped addresses read zero
  always @* begin
    rdMux = 32'h0000_0000;
    case (regAddr)
      `OFS_C1_VARSEL:   rdMux[5:0]       = c1VarSel_q;
      `OFS_C1_METHOD:   rdMux[3:0]       = c1Method_q;
      `OFS_C1_DEADZONE: rdMux[VAR_W-1:0] = c1DeadZone_q;
      `OFS_C1_VALUE_A:  rdMux[VAR_W-1:0] = c1ValueA_q;
      `OFS_C1_VALUE_B:  rdMux[VAR_W-1:0] = c1ValueB_q;
      `OFS_C2_VARSEL:   rdMux[5:0]       = c2VarSel_q;
      `OFS_C2_METHOD:   rdMux[3:0]       = c2Method_q;
      `OFS_C2_DEADZONE: rdMux[VAR_W-1:0] = c2DeadZone_q;
      `OFS_C2_VALUE_A:  rdMux[VAR_W-1:0] = c2ValueA_q;
      `OFS_C2_VALUE_B:  rdMux[VAR_W-1:0] = c2ValueB_q;
      `OFS_TERM0_FUNC:  rdMux[5:0]       = term0Func_q;
      `OFS_TERM1_FUNC:  rdMux[5:0]       = term1Func_q;
      `OFS_TERM2_FUNC:  rdMux[5:0]       = term2Func_q;
      `OFS_POLARITY: begin
        rdMux[NUM_TERMS-1:0] = polarity_q;
      end
      // Live state: results and contacts
      `OFS_STATUS: begin
        rdMux[`STAT_CMP_LSB]     = c1Result;
        rdMux[`STAT_CMP_LSB + 1] = c2Result;
        rdMux[`STAT_TERM_LSB +: NUM_TERMS] = termClosed_q;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      regRdData_q <= 32'h0000_0000;
    else if (regRead)
      regRdData_q <= rdMux;
    else
      regRdData_q <= 32'h0000_0000;
  end

endmodule

// ===== verification/terminal_load.sv
// Relay driver model behind the output terminals
`timescale 1ns/1ps

module terminal_load #(
  parameter SETTLE = 2
) (
  // Clock and reset
  input  wire       clock,
  input  wire       arst_n,
  // Contacts from the block, load state seen
  input  wire [2:0] termClosed,
  output wire [2:0] loadOn
);
  // ==========================================================
  // Coil pull-in takes SETTLE cycles, so short glitches are seen late
  reg [3*SETTLE-1:0] pipe_q;

  // Shift the contact state through the pull-in delay
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      pipe_q <= {3*SETTLE{1'b0}};
    else
      pipe_q <= {pipe_q[3*SETTLE-4:0], termClosed};
  end
  assign loadOn = pipe_q[3*SETTLE-1 -: 3];
endmodule

// ===== verification/user_output_block_chk.sv
// Port checker for the user-defined output block
`timescale 1ns/1ps
`include "user_output_consts.vh"

module user_output_block_chk (
  // Clock and reset
  input wire        clock,
  input wire        arst_n,
  // Register port
  input wire [7:0]  regAddr,
  input wire [31:0] regWrData,
  input wire        regWrite,
  input wire        regRead,
  input wire [31:0] regRdData_q,
  // Terminals
  input wire [2:0]  externalActive,
  input wire [2:0]  termClosed_q
);
  // ==========================================================
  // Shadows of the settings that the properties depend on
  reg [3:0] method1_q;
  reg [5:0] func0_q;
  reg       pol0_q;
  reg [2:0] run_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Track accepted writes; out-of-range methods are dropped
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      method1_q <= 4'h0;
      func0_q   <= 6'h00;
      pol0_q    <= 1'b0;
      run_q     <= 3'h0;
    end else begin
      if (regWrite && regAddr == `OFS_C1_METHOD && regWrData <= 32'he)
        method1_q <= regWrData[3:0];
      if (regWrite && regAddr == `OFS_TERM0_FUNC)
        func0_q <= regWrData[5:0];
      if (regWrite && regAddr == `OFS_POLARITY)
        pol0_q <= regWrData[0];
      if (run_q != 3'h7)
        run_q <= run_q + 3'h1;
    end
  end

  // ==========================================================
  // Properties
  sequence readOf(logic [7:0] a);
    regRead && regAddr == a;
  endsequence

  read_idle_a: assert property (!$past(regRead) |-> regRdData_q == 32'h0)
    else $error("read data not zero outside a read answer");
  value_width_a: assert property (readOf(`OFS_C1_VALUE_A) |=>
    regRdData_q[31:16] == 16'h0) else $error("compare value too wide");
  varsel_range_a: assert property (readOf(`OFS_C1_VARSEL) |=>
    regRdData_q <= 32'h31) else $error("variable select above 49");
  method_range_a: assert property (readOf(`OFS_C1_METHOD) |=>
    regRdData_q <= 32'he) else $error("method above 14");
  method_refuse_a: assert property (readOf(`OFS_C1_METHOD) |=>
    regRdData_q[3:0] == $past(method1_q))
    else $error("method write mishandled");
  second_range_a: assert property (readOf(`OFS_C2_VARSEL) |=>
    regRdData_q <= 32'h31) else $error("second select above 49");
  term_follow_a: assert property (
    run_q == 3'h7 && func0_q != `FUNC_USER1
    && func0_q != `FUNC_USER2 && !$past(regWrite) && !$past(regWrite, 2)
    && $past(externalActive[0]) == externalActive[0]
    && $past(externalActive[0], 2) == externalActive[0]
    |-> termClosed_q[0] == (externalActive[0] ^ pol0_q))
    else $error("terminal 0 contact wrong");
  status_mirror_a: assert property (readOf(`OFS_STATUS) |=>
    regRdData_q[6:4] == $past(termClosed_q))
    else $error("status mirror wrong");
endmodule

bind user_output_block user_output_block_chk chk (
  .clock(clock), .arst_n(arst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData_q(regRdData_q), .externalActive(externalActive),
  .termClosed_q(termClosed_q));

// ===== verification/user_output_block_tb.sv
// Self-checking bench for the user-defined output block
`timescale 1ns/1ps
`include "user_output_consts.vh"

module user_output_block_tb;
  // ==========================================================
  // Signals
  reg          clock;
  reg          arst_n;
  reg  [7:0]   regAddr;
  reg  [31:0]  regWrData;
  reg          regWrite;
  reg          regRead;
  wire [31:0]  regRdData_q;
  reg  [799:0] variables;
  reg  [2:0]   externalActive;
  wire [2:0]   termClosed_q;
  wire [2:0]   loadOn;
  integer      numErrors;
  integer      testsRun;
  integer      i;
  integer      c;
  integer      tbl [0:19][0:5];

  user_output_block uut (.clock(clock), .arst_n(arst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData_q(regRdData_q), .variables(variables),
    .externalActive(externalActive), .termClosed_q(termClosed_q));
  terminal_load #(.SETTLE(2)) load (.clock(clock), .arst_n(arst_n),
    .termClosed(termClosed_q), .loadOn(loadOn));

  // 250 MHz clock
  initial clock = 1'b0;
  always #2 clock = ~clock;

  // ==========================================================
  // Tasks
  task check(input string name, input [31:0] e, input [31:0] g);
    begin
      testsRun = testsRun + 1;
      if (g !== e) begin
        numErrors = numErrors + 1;
        $display("MISMATCH %0s exp %h got %h", name, e, g);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
    end
  endtask

  // Read data stands only in the cycle after the strobe
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      check("readback", e, regRdData_q);
    end
  endtask

  // Two edges through comparator and terminal flop, one spare
  task settle;
    begin
      repeat (3) @(posedge clock);
      #1;
    end
  endtask

  task printVerdict;
    begin
      $display("checks %0d errors %0d", testsRun, numErrors);
      if (numErrors == 0 && testsRun > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // Watchdog, far beyond the roughly 560 cycles the run needs
  initial begin
    repeat (20000) @(posedge clock);
    numErrors = numErrors + 1;
    printVerdict;
  end

  // ==========================================================
  // Main sequence: method, dead zone, A, B, variable, contact
  initial begin
    tbl = '{'{11,0,2000,0,1999,0}, '{11,0,2000,0,2000,1},
      '{1,50,5000,0,4900,1}, '{1,50,5000,0,5000,1}, '{1,50,5000,0,5050,0},
      '{1,50,5000,0,4951,0}, '{1,50,5000,0,4950,1}, '{12,0,100,0,100,1},
      '{12,0,100,0,101,0}, '{13,0,300,600,300,0}, '{13,0,300,600,301,1},
      '{13,0,300,600,600,1}, '{13,0,300,600,601,0}, '{14,0,8,8,12,1},
      '{14,0,8,8,4,0}, '{10,0,77,0,77,1}, '{0,0,77,0,77,0},
      '{5,0,0,0,0,1}, '{3,5,300,600,400,0}, '{2,0,100,0,100,0}};
    numErrors = 0;
    testsRun = 0;
    arst_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    variables = {800{1'b1}};
    externalActive = 3'h0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    for (i = 0; i <= 'h34; i = i + 4)
      rd(i[7:0], 32'h0);
    rd(`OFS_STATUS, 32'h3);
    rd(8'h3c, 32'h0);
    // Out-of-range selects and methods are dropped; values keep their low bits
    wr(`OFS_C1_VARSEL, 32'h3);
    wr(`OFS_C1_VARSEL, 32'h32);
    rd(`OFS_C1_VARSEL, 32'h3);
    wr(`OFS_C2_VARSEL, 32'h31);
    rd(`OFS_C2_VARSEL, 32'h31);
    wr(`OFS_C1_METHOD, 32'hf);
    rd(`OFS_C1_METHOD, 32'h0);
    wr(`OFS_C1_VALUE_A, 32'h1ffff);
    rd(`OFS_C1_VALUE_A, 32'hffff);
    wr(`OFS_TERM1_FUNC, 32'h29);
    wr(`OFS_TERM2_FUNC, 32'h2a);
    // Polarity on a terminal fed by another function
    externalActive <= 3'h1;
    settle;
    check("term0", 32'h1, termClosed_q[0]);
    wr(`OFS_POLARITY, 32'h1);
    // Contact moves one edge after the write; the load lags behind it
    @(posedge clock);
    #1;
    check("term0", 32'h0, termClosed_q[0]);
    check("load0", 32'h1, loadOn[0]);
    settle;
    check("load0", 32'h0, loadOn[0]);
    wr(`OFS_POLARITY, 32'h0);
    // Every method row on both comparators, state carried row to row
    for (c = 0; c < 2; c = c + 1)
      for (i = 0; i < 20; i = i + 1) begin
        wr(8'h04 + c * 20, tbl[i][0]);
        wr(8'h08 + c * 20, tbl[i][1]);
        wr(8'h0c + c * 20, tbl[i][2]);
        wr(8'h10 + c * 20, tbl[i][3]);
        @(posedge clock);
        variables[(c ? 49 : 3) * 16 +: 16] <= tbl[i][4];
        settle;
        check("contact", tbl[i][5], termClosed_q[c + 1]);
      end
    // Inverse polarity on a comparator-driven terminal
    wr(`OFS_POLARITY, 32'h2);
    settle;
    check("term1", 32'h1, termClosed_q[1]);
    rd(`OFS_STATUS, 32'h30);
    // Reset in mid-run returns every setting to zero
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rd(`OFS_POLARITY, 32'h0);
    rd(`OFS_C1_METHOD, 32'h0);
    check("contacts", 32'h1, termClosed_q);
    printVerdict;
  end
endmodule
